// *** pfr_consts.vh ***
// Constants for the power-fail and auto-restart sequencer
`ifndef PFR_CONSTS_VH
`define PFR_CONSTS_VH
`define PFR_CLK_PERIOD_NS     50
`define PFR_INIT_PULSE_US     70000
`define PFR_GUARD_US          2000
`define PFR_POWER_DOWN_PULSE_US           8000
`define PFR_INIT_CYCLES       ((`PFR_INIT_PULSE_US * 1000) / `PFR_CLK_PERIOD_NS)
`define PFR_GUARD_CYCLES      ((`PFR_GUARD_US * 1000) / `PFR_CLK_PERIOD_NS)
`define PFR_POWER_DOWN_PULSE_CYCLES       ((`PFR_POWER_DOWN_PULSE_US * 1000) / `PFR_CLK_PERIOD_NS)
`define PFR_VEC_PC_ADDR       16'h0014
`define PFR_VEC_PSW_ADDR      16'h0016
`define PFR_ADDR_STATUS       12'h000
`define PFR_ADDR_MASK         12'h004
`define PFR_ADDR_CTRL         12'h008
`define PFR_ADDR_STATE        12'h00C
`define PFR_EV_INIT_DONE      0
`define PFR_EV_POWER_DOWN_PULSE_REQ       1
`define PFR_EV_TRAP_TAKEN     2
`define PFR_EV_MOMENTARY      3
`define PFR_EV_HALTED         4
`define PFR_NEV               5
`define PFR_CTRL_CONS_LOCK    0
`define PFR_CTRL_HALT_SW      1
`endif

// *** pfr_power_fail_restart.v ***
// Power-fail and auto-restart sequencer with APB status and control
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "pfr_consts.vh"

module pfr_power_fail_restart #(
   parameter [31:0] INIT_CYCLES  = `PFR_INIT_CYCLES,
   parameter [31:0] GUARD_CYCLES = `PFR_GUARD_CYCLES,
   parameter [31:0] POWER_DOWN_PULSE_CYCLES  = `PFR_POWER_DOWN_PULSE_CYCLES
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        clk_en,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   output wire        irq,
   input  wire        ac_low_warning_n,
   input  wire        dc_low_shutdown_n,
   input  wire        service_branch_test,
   input  wire        trap_grant,
   output reg         init_pulse,
   output reg         power_up_guard_timer,
   output reg         power_down_pulse,
   output reg         power_down_request_synced,
   output reg         restart_vector_req,
   output reg         power_fail_trap,
   output reg         push_pc_psw,
   output reg  [15:0] vector_pc_addr,
   output reg  [15:0] vector_psw_addr,
   output reg         halted
);

   // Sequencer states; halt behaves as run but the core stays stopped
   localparam [2:0] ST_OFF   = 3'h0;
   localparam [2:0] ST_INIT  = 3'h1;
   localparam [2:0] ST_GUARD = 3'h2;
   localparam [2:0] ST_RUN   = 3'h3;
   localparam [2:0] ST_POWER_DOWN_PULSE  = 3'h4;
   localparam [2:0] ST_HALT  = 3'h5;

   // Line levels, high while the line is asserted
   wire [1:0]  pin_low;
   wire [1:0]  flt_low;
   wire        ac_low_q;
   wire        dc_low_q;
   reg  [2:0]  state_q;
   reg  [31:0] cnt_q;
   reg         power_down_pulse_flag_q;
   reg  [`PFR_NEV-1:0] status_q;
   reg  [`PFR_NEV-1:0] mask_q;
   reg  [1:0]  ctrl_q;
   reg  [31:0] rdata_q;
   wire        wr_en;
   wire        rd_en;
   wire        addr_ok;
   reg  [`PFR_NEV-1:0] ev;
   // Phase ends, register strobes and read view
   wire        init_end;
   wire        guard_end;
   wire        power_down_pulse_end;
   wire        wr_status;
   wire        wr_mask;
   wire        wr_ctrl;
   wire [`PFR_NEV-1:0] clr_bits;
   wire [31:0] state_word;

   // Pins are active low; flip so one means asserted
   assign pin_low  = {~dc_low_shutdown_n, ~ac_low_warning_n};
   assign ac_low_q = flt_low[0];
   assign dc_low_q = flt_low[1];

   // three-flop catch per line, agreement filter
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_line
         reg  [2:0]  sync_q;
         reg         lvl_q;
         // Start asserted: no false release edge after reset
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync_q <= 3'h7;
            end else if (clk_en) begin
               sync_q <= {sync_q[1:0], pin_low[gi]};
            end
         end
         // Level moves only once stages two and three agree
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lvl_q <= 1'b1;
            end else if (clk_en && (sync_q[1] == sync_q[2])) begin
               lvl_q <= sync_q[2];
            end
         end
         assign flt_low[gi] = lvl_q;
      end
   endgenerate

   // terminal counts of init, guard and power-down phases
   assign init_end  = (cnt_q >= INIT_CYCLES - 32'h1);
   assign guard_end = (cnt_q >= GUARD_CYCLES - 32'h1);
   assign power_down_pulse_end  = (cnt_q >= POWER_DOWN_PULSE_CYCLES - 32'h1);

   // Main power sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q                   <= ST_OFF;
         cnt_q                     <= 32'h0000_0000;
         init_pulse                <= 1'b1;
         power_up_guard_timer      <= 1'b0;
         power_down_pulse          <= 1'b0;
         power_down_pulse_flag_q               <= 1'b0;
         power_down_request_synced <= 1'b0;
         restart_vector_req        <= 1'b0;
         power_fail_trap           <= 1'b0;
         push_pc_psw               <= 1'b0;
         vector_pc_addr            <= 16'h0000;
         vector_psw_addr           <= 16'h0000;
         halted                    <= 1'b0;
         ev                        <= {`PFR_NEV{1'b0}};
      end else if (clk_en) begin
         ev                 <= {`PFR_NEV{1'b0}};
         restart_vector_req <= 1'b0;
         power_fail_trap    <= 1'b0;
         push_pc_psw        <= 1'b0;

         power_down_request_synced <= power_down_pulse_flag_q;
         if (power_down_request_synced && service_branch_test && trap_grant) begin
            power_fail_trap           <= 1'b1;
            push_pc_psw               <= 1'b1;
            vector_pc_addr            <= `PFR_VEC_PC_ADDR;
            vector_psw_addr           <= `PFR_VEC_PSW_ADDR;
            power_down_pulse_flag_q               <= 1'b0;
            power_down_request_synced <= 1'b0;
            ev[`PFR_EV_TRAP_TAKEN]    <= 1'b1;
         end

         // Phase sequencing; a dc-low anywhere falls back to off
         case (state_q)
            ST_OFF: begin
               // hold everything in init while dc-low
               init_pulse <= 1'b1;
               cnt_q      <= 32'h0000_0000;
               if (!dc_low_q)
                  state_q <= ST_INIT;
            end
            ST_INIT: begin
               init_pulse <= 1'b1;
               if (dc_low_q) begin
                  state_q <= ST_OFF;
               end else if (init_end) begin
                  // guard only without ac-low
                  // While ac-low stays asserted the init pulse stretches
                  if (!ac_low_q) begin
                     cnt_q                 <= 32'h0000_0000;
                     init_pulse            <= 1'b0;
                     ev[`PFR_EV_INIT_DONE] <= 1'b1;
                     power_up_guard_timer  <= 1'b1;
                     if (ctrl_q[`PFR_CTRL_HALT_SW] && !ctrl_q[`PFR_CTRL_CONS_LOCK]) begin
                        halted  <= 1'b1;
                        ev[`PFR_EV_HALTED] <= 1'b1;
                     end else begin
                        restart_vector_req <= 1'b1;
                        vector_pc_addr     <= `PFR_VEC_PC_ADDR;
                        vector_psw_addr    <= `PFR_VEC_PSW_ADDR;
                     end
                     state_q <= ST_GUARD;
                  end
               end else begin
                  cnt_q <= cnt_q + 32'd1;
               end
            end
            ST_GUARD: begin
               if (dc_low_q) begin
                  power_up_guard_timer <= 1'b0;
                  state_q <= ST_OFF;
               end else if (guard_end) begin
                  cnt_q                <= 32'h0000_0000;
                  power_up_guard_timer <= 1'b0;
                  state_q              <= halted ? ST_HALT : ST_RUN;
               end else begin
                  cnt_q <= cnt_q + 32'd1;
               end
            end
            ST_RUN, ST_HALT: begin
               if (dc_low_q) begin
                  state_q <= ST_OFF;
                  halted  <= 1'b0;
               end else if (ac_low_q) begin
                  // Guard has expired, so ac-low now counts
                  // fire pulse, set unsynced flag
                  power_down_pulse      <= 1'b1;
                  power_down_pulse_flag_q           <= 1'b1;
                  cnt_q                 <= 32'h0000_0000;
                  ev[`PFR_EV_POWER_DOWN_PULSE_REQ]  <= 1'b1;
                  state_q               <= ST_POWER_DOWN_PULSE;
               end
            end
            ST_POWER_DOWN_PULSE: begin
               if (dc_low_q) begin
                  // Real failure: shutdown takes over
                  power_down_pulse <= 1'b0;
                  power_down_pulse_flag_q      <= 1'b0;
                  halted           <= 1'b0;
                  state_q          <= ST_OFF;
               end else if (power_down_pulse_end) begin
                  power_down_pulse     <= 1'b0;
                  power_down_pulse_flag_q          <= 1'b0;
                  halted               <= 1'b0;
                  cnt_q                <= 32'h0000_0000;
                  init_pulse           <= 1'b1;
                  ev[`PFR_EV_MOMENTARY] <= 1'b1;
                  state_q              <= ST_INIT;
               end else begin
                  cnt_q <= cnt_q + 32'd1;
               end
            end
            default: begin
               state_q <= ST_OFF;
            end
         endcase
      end
   end

   // APB decode: zero wait states, no errors
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & ~penable & ~pwrite;
   assign addr_ok = 1'b1;
   assign prdata  = rdata_q;
   assign irq     = |(status_q & mask_q);

   // Per-register write strobes and write-one-to-clear bits
   assign wr_status = wr_en & (paddr == `PFR_ADDR_STATUS);
   assign wr_mask   = wr_en & (paddr == `PFR_ADDR_MASK);
   assign wr_ctrl   = wr_en & (paddr == `PFR_ADDR_CTRL);
   assign clr_bits  = wr_status ? pwdata[`PFR_NEV-1:0] : {`PFR_NEV{1'b0}};

   // Read-only view of the sequencer for software
   assign state_word = {23'h0, halted, power_down_request_synced, power_down_pulse,
                        power_up_guard_timer, init_pulse, dc_low_q, state_q};

   // Register writes, sticky status; set beats clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= {`PFR_NEV{1'b0}};
         mask_q   <= {`PFR_NEV{1'b0}};
         ctrl_q   <= 2'b00;
      end else if (clk_en) begin
         // Event set wins over a clear in the same cycle
         status_q <= (status_q & ~clr_bits) | ev;
         if (wr_mask)
            mask_q <= pwdata[`PFR_NEV-1:0];
         if (wr_ctrl)
            ctrl_q <= pwdata[1:0];
      end
   end

   // Read data captured in setup phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (clk_en && rd_en && addr_ok) begin
         case (paddr)
            `PFR_ADDR_STATUS: rdata_q <= {27'h0, status_q};
            `PFR_ADDR_MASK:   rdata_q <= {27'h0, mask_q};
            `PFR_ADDR_CTRL:   rdata_q <= {30'h0, ctrl_q};
            `PFR_ADDR_STATE:  rdata_q <= state_word;
            default:          rdata_q <= 32'h0000_0000;
         endcase
      end
   end

endmodule // pfr_power_fail_restart

// *** pfr_power_fail_restart_sva.sv ***
// Assertion checker for the power-fail sequencer ports
`timescale 1ns/10ps
module pfr_power_fail_restart_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        service_branch_test,
   input wire logic        trap_grant,
   input wire logic        init_pulse,
   input wire logic        power_up_guard_timer,
   input wire logic        power_down_pulse,
   input wire logic        power_down_request_synced,
   input wire logic        restart_vector_req,
   input wire logic        power_fail_trap,
   input wire logic        push_pc_psw,
   input wire logic [15:0] vector_pc_addr,
   input wire logic [15:0] vector_psw_addr,
   input wire logic        halted
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Start points of the power-down pulse and the guard window
   sequence s_power_down_pulse_start; $rose(power_down_pulse); endsequence
   sequence s_guard_start; $rose(power_up_guard_timer); endsequence
   a_trap_once: assert property (power_fail_trap |=> !power_fail_trap)
      else $error("trap pulse too long");
   a_trap_cause: assert property (power_fail_trap |-> $past(service_branch_test && trap_grant && power_down_request_synced))
      else $error("trap without service test");
   a_trap_push: assert property (power_fail_trap |-> push_pc_psw)
      else $error("trap without stacking");
   a_vector_load: assert property ((restart_vector_req || power_fail_trap) |-> ##[0:1] (vector_pc_addr == 16'h0014 && vector_psw_addr == 16'h0016))
      else $error("wrong vector addresses");
   a_restart_nostack: assert property (restart_vector_req |-> !push_pc_psw && !halted)
      else $error("restart stacked or halted");
   a_guard_blocks: assert property (power_up_guard_timer |-> !power_down_pulse)
      else $error("power-down inside guard");
   a_guard_after_init: assert property (s_guard_start |-> $past(init_pulse))
      else $error("guard not at init end");
   a_guard_hold: assert property (s_guard_start |-> power_up_guard_timer[*8])
      else $error("guard window too short");
   a_power_down_pulse_sync: assert property (s_power_down_pulse_start |-> ##[1:2] power_down_request_synced)
      else $error("request did not follow pulse");
endmodule // pfr_power_fail_restart_sva

// *** pfr_supply_model.sv ***
// Model of the power supplies driving the two status lines
`timescale 1ns/10ps
module pfr_supply_model #(parameter int GAP = 40) (
   input wire logic supply_ok,
   input wire logic dip,
   input wire logic pclk,
   output logic     ac_low_warning_n,
   output logic     dc_low_shutdown_n
);
   logic ok_q  = 1'b0;
   int   cnt_q = 0;
   initial begin
      ac_low_warning_n = 1'b0;
      dc_low_shutdown_n = 1'b0;
   end
   // Gap counter restarts on every supply change
   always @(posedge pclk) begin
      ok_q <= supply_ok;
      cnt_q <= (supply_ok != ok_q) ? 0 : (cnt_q < GAP ? cnt_q + 1 : cnt_q);
      if (supply_ok) dc_low_shutdown_n <= 1'b1;
      ac_low_warning_n <= supply_ok && ok_q && !dip && cnt_q >= GAP;
      // dc falls a gap after ac
      if (!supply_ok && !ok_q && cnt_q >= GAP) dc_low_shutdown_n <= 1'b0;
   end
endmodule // pfr_supply_model

// *** tb_power_fail_restart.sv ***
// Self-checking bench for the power-fail sequencer
`timescale 1ns/10ps
module tb_power_fail_restart;
   logic        pclk, presetn, clk_en, psel, penable, pwrite;
   logic        service_branch_test, trap_grant, supply_ok, dip;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   wire  [31:0] prdata;
   wire         pready, pslverr, irq, ac_low_warning_n, dc_low_shutdown_n, halted;
   wire         init_pulse, power_up_guard_timer, power_down_pulse, power_down_request_synced;
   wire         restart_vector_req, power_fail_trap, push_pc_psw;
   wire  [15:0] vector_pc_addr, vector_psw_addr;
   wire  [4:0]  ev = {halted, power_fail_trap, power_down_request_synced, restart_vector_req, init_pulse};
   int          n_fail = 0;
   int          tests_run = 0;

   pfr_power_fail_restart #(.INIT_CYCLES(20), .GUARD_CYCLES(30), .POWER_DOWN_PULSE_CYCLES(15)) i_dut (
      .pclk                      (pclk),
      .presetn                   (presetn),
      .clk_en                    (clk_en),
      .psel                      (psel),
      .penable                   (penable),
      .pwrite                    (pwrite),
      .paddr                     (paddr),
      .pwdata                    (pwdata),
      .prdata                    (prdata),
      .pready                    (pready),
      .pslverr                   (pslverr),
      .irq                       (irq),
      .ac_low_warning_n          (ac_low_warning_n),
      .dc_low_shutdown_n         (dc_low_shutdown_n),
      .service_branch_test       (service_branch_test),
      .trap_grant                (trap_grant),
      .init_pulse                (init_pulse),
      .power_up_guard_timer      (power_up_guard_timer),
      .power_down_pulse          (power_down_pulse),
      .power_down_request_synced (power_down_request_synced),
      .restart_vector_req        (restart_vector_req),
      .power_fail_trap           (power_fail_trap),
      .push_pc_psw               (push_pc_psw),
      .vector_pc_addr            (vector_pc_addr),
      .vector_psw_addr           (vector_psw_addr),
      .halted                    (halted)
   );
   pfr_supply_model #(.GAP(40)) i_sup (
      .supply_ok                 (supply_ok),
      .dip                       (dip),
      .pclk                      (pclk),
      .ac_low_warning_n          (ac_low_warning_n),
      .dc_low_shutdown_n         (dc_low_shutdown_n)
   );

   // Clock of 50 ns period
   always #25 pclk = ~pclk;

   task close_out;
      $display("checks %0d fails %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask

   // Bounded wait on one event line
   task wt(input int k);
      int i;
      for (i = 0; i < 300 && ev[k] !== 1'b1; i++) @(posedge pclk);
      chk("wait", 1, ev[k]);
      if (ev[k] !== 1'b1) close_out;
   endtask

   // One APB transfer; edge first so psel never changes twice in a step
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      psel <= 0;
      penable <= 0;
      chk("pslverr", 0, pslverr);
      chk("pready", 1, pready);
      if (pready !== 1'b1) close_out;
   endtask

   initial begin
      pclk = 0; presetn = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
      paddr = 0; pwdata = 0; service_branch_test = 0; trap_grant = 0; supply_ok = 0; dip = 0;
      repeat (4) @(posedge pclk);
      chk("init in reset", 1, init_pulse);
      presetn <= 1;
      apb(1, 12'h008, 32'h3);
      apb(1, 12'h004, 32'h1F);
      supply_ok <= 1;
      wt(1);
      chk("guard", 1, power_up_guard_timer);
      @(posedge pclk);
      chk("pc vector", 16'h0014, vector_pc_addr);
      chk("psw vector", 16'h0016, vector_psw_addr);
      chk("halted", 0, halted);
      dip <= 1;
      repeat (8) @(posedge pclk);
      chk("power_down_pulse in guard", 0, power_down_pulse);
      dip <= 0;
      repeat (30) @(posedge pclk);
      apb(0, 12'h000, 32'h0);
      chk("status", 32'h1, rd);
      chk("irq", 1, irq);
      apb(1, 12'h000, 32'h1F);
      @(posedge pclk);
      chk("irq cleared", 0, irq);
      dip <= 1;
      wt(2);
      repeat (3) @(posedge pclk);
      chk("early trap", 0, power_fail_trap);
      service_branch_test <= 1;
      trap_grant <= 1;
      wt(3);
      chk("push", 1, push_pc_psw);
      service_branch_test <= 0;
      trap_grant <= 0;
      chk("irq trap", 1, irq);
      apb(1, 12'h004, 32'h0);
      @(posedge pclk);
      chk("irq masked", 0, irq);
      dip <= 0;
      wt(1);
      apb(0, 12'h000, 32'h0);
      chk("status", 32'hF, rd);
      apb(0, 12'h010, 32'h0);
      chk("unmapped", 0, rd);
      apb(1, 12'h008, 32'h2);
      supply_ok <= 0;
      repeat (60) @(posedge pclk);
      chk("init at dc low", 1, init_pulse);
      supply_ok <= 1;
      wt(4);
      chk("no restart", 0, restart_vector_req);
      apb(0, 12'h00C, 32'h0);
      chk("state word", 32'h122, rd);
      clk_en <= 0;
      apb(1, 12'h004, 32'h1F);
      clk_en <= 1;
      apb(0, 12'h004, 32'h0);
      chk("mask frozen", 0, rd);
      close_out;
   end
endmodule // tb_power_fail_restart

bind pfr_power_fail_restart pfr_power_fail_restart_sva i_sva (
   .pclk                      (pclk),
   .presetn                   (presetn),
   .service_branch_test       (service_branch_test),
   .trap_grant                (trap_grant),
   .init_pulse                (init_pulse),
   .power_up_guard_timer      (power_up_guard_timer),
   .power_down_pulse          (power_down_pulse),
   .power_down_request_synced (power_down_request_synced),
   .restart_vector_req        (restart_vector_req),
   .power_fail_trap           (power_fail_trap),
   .push_pc_psw               (push_pc_psw),
   .vector_pc_addr            (vector_pc_addr),
   .vector_psw_addr           (vector_psw_addr),
   .halted                    (halted)
);
